// ---- rtl/mda_alu_unit.sv ----
/*
  Multiply, divide and shift part of the core ALU with issue interlock,
  a one-entry result scoreboard and an AXI4-Lite control port.
  Assumes the pipeline holds a request until iss_ack and owns forwarding.
*/
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
// Notes on behaviour
// RQ1 - Identity register holds a build constant, unique per core in the system.
// RQ2 - Without multiply or divide hardware those instructions raise an exception.
// RQ3 - Logic-built option: 32x4 array, 11 issue cycles, 2 latency cycles.
// RQ4 - Full embedded option: 32x32, one per cycle, low, immediate and high forms; the unit takes a new request only every second cycle.
// RQ5 - Half embedded option: 32x16, 5 issue cycles, no high-word forms.
// RQ6 - Divider is multicycle logic, signed and unsigned, four to sixty-six cycles.
// RQ7 - Results usable two cycles after issue completes; consumers stall until then.
// RQ8 - Independent instructions see no stall from a pending result.
// RQ9 - Issue cycle count limits acceptance and result rate per option.
// RQ10 - Ordinary arithmetic completes in one cycle when not waiting.
// RQ11 - Without multiplier, shifts advance one bit per cycle.
// RQ12 - Multiplier choice at build time: none, embedded or logic-built.
// RQ13 - With multiplier, shifts and rotates use it and finish in one cycle.
// RQ14 - A stalled stage takes no new values; nothing behind it catches up.
// RQ15 - Track pending destination, compare with younger sources to stall.
// RQ16 - A multicycle operation keeps its slot busy until its final cycle.
`timescale 1ns/1ps
module mda_alu_unit #(
  parameter int MUL_MODE = mda_pkg::MUL_EMB32,
  parameter bit DIV_EN = 1'b1,
  parameter logic [31:0] CORE_ID = 32'h0000_0001 // Arbitrary, set per core
) (
  input wire logic aclk,               // Core clock
  input wire logic aresetn,            // Sync reset, low
  input wire logic iss_valid,          // Request held until ack
  input wire logic [3:0] iss_op,       // Operation code
  input wire logic [4:0] iss_dst,      // Destination register
  input wire logic [4:0] iss_src_a,    // Source register a
  input wire logic [4:0] iss_src_b,    // Source register b
  input wire logic [31:0] opnd_a,      // Operand a
  input wire logic [31:0] opnd_b,      // Operand b or immediate
  output logic iss_ack,                // Request taken pulse
  output logic iss_exc,                // Unsupported op pulse
  output logic wb_valid,               // One-cycle result
  output logic [4:0] wb_dst,           // Its register
  output logic [31:0] wb_data,         // Its value
  output logic lwb_valid,              // Long result
  output logic [4:0] lwb_dst,          // Its register
  output logic [31:0] lwb_data,        // Its value
  input wire logic awvalid,            // AXI write address
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,             // AXI write data
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,                 // AXI write response
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,            // AXI read address
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,                 // AXI read data
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq                     // Level, masked status
);
  // ****************************************
  // Build options
  // ****************************************
  localparam int C_LE = mda_pkg::LE_ISSUE_CYC;
  localparam int ISS = (MUL_MODE == mda_pkg::MUL_LE) ? mda_pkg::LE_ISSUE_CYC :
                       (MUL_MODE == mda_pkg::MUL_EMB16) ? mda_pkg::E16_ISSUE_CYC : mda_pkg::E32_ISSUE_CYC;
  localparam int CHK = (MUL_MODE == mda_pkg::MUL_LE) ? mda_pkg::LE_CHUNK :
                       (MUL_MODE == mda_pkg::MUL_EMB16) ? mda_pkg::E16_CHUNK : mda_pkg::E32_CHUNK;
  localparam bit HAS_MUL = MUL_MODE != mda_pkg::MUL_NONE;

  if (MUL_MODE < 0 || MUL_MODE > 3) begin : g_bad // [RQ12]
    $error("mda_alu_unit: MUL_MODE must be 0 to 3");
  end

  function automatic logic [31:0] rev(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) r[i] = v[31 - i];
    return r;
  endfunction : rev

  // Shift by multiplying with a power of two; right shifts go through reversal
  function automatic logic [31:0] mshift(input logic [3:0] op, input logic [31:0] a, input logic [4:0] n);
    logic [63:0] pl;
    logic [63:0] pr;
    logic [31:0] fill;
    pl = {32'h0, a} * {32'h0, 32'h1 << n};
    pr = {32'h0, rev(a)} * {32'h0, 32'h1 << n};
    fill = a[31] ? ~(32'hffff_ffff >> n) : 32'h0;
    case (op)
      mda_pkg::OP_SLL: return pl[31:0];
      mda_pkg::OP_ROL: return pl[31:0] | pl[63:32];
      mda_pkg::OP_SRL: return rev(pr[31:0]);
      default: return rev(pr[31:0]) | fill;
    endcase
  endfunction : mshift

  // ****************************************
  // Decode and interlock
  // ****************************************
  logic ack_r, exc_r, busy_r, pend_r, en_r;
  logic [4:0] pdst_r;
  wire logic op_mlo = iss_op == mda_pkg::OP_MUL || iss_op == mda_pkg::OP_MULI;
  wire logic op_mhi = iss_op >= mda_pkg::OP_MULXSS && iss_op <= mda_pkg::OP_MULXUU;
  wire logic op_div = iss_op == mda_pkg::OP_DIV || iss_op == mda_pkg::OP_DIVU;
  wire logic op_shf = iss_op >= mda_pkg::OP_SLL && iss_op <= mda_pkg::OP_ROL;
  wire logic unsup = (op_mlo && !HAS_MUL) || (op_mhi && MUL_MODE != mda_pkg::MUL_EMB32) // [RQ2] [RQ5]
                     || (op_div && !DIV_EN) || iss_op > mda_pkg::OP_ROL;
  wire logic is_long = !unsup && (op_mlo || op_mhi || op_div || (op_shf && !HAS_MUL));
  wire logic is_short = !unsup && !is_long;
  wire logic hazard = pend_r && (iss_src_a == pdst_r || iss_src_b == pdst_r || iss_dst == pdst_r); // [RQ15]
  wire logic req = iss_valid && !ack_r;
  wire logic blocked = !en_r || hazard || (is_long && busy_r); // [RQ7] [RQ9] [RQ16]
  wire logic take = req && !blocked; // [RQ14]
  wire logic st_mul = take && (op_mlo || op_mhi) && !unsup;
  wire logic st_div = take && op_div && !unsup;
  wire logic st_shf = take && op_shf && !HAS_MUL;
  wire logic [1:0] hi_sel = op_mhi ? 2'(iss_op - mda_pkg::OP_MULXSS + 4'h1) : 2'h0;

  // ****************************************
  // Arithmetic engines
  // ****************************************
  logic mul_done, div_done, shf_done_r, shf_run_r;
  logic [31:0] mul_p, div_q, shf_v_r;
  logic [4:0] shf_n_r;
  logic [3:0] shf_op_r;

  mda_mul #(.CHUNK(CHK), .ISSUE(ISS)) u_mul ( // [RQ3] [RQ4] [RQ5]
    .aclk(aclk), .aresetn(aresetn), .start(st_mul), .a(opnd_a), .b(opnd_b),
    .hi_sel(hi_sel), .done(mul_done), .p(mul_p)
  );

  mda_div u_div ( // [RQ6]
    .aclk(aclk), .aresetn(aresetn), .start(st_div), .sgn(iss_op == mda_pkg::OP_DIV),
    .a(opnd_a), .b(opnd_b), .done(div_done), .q(div_q)
  );

  // Serial shifter, one bit per cycle when no multiplier is built
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shf_v_r <= 32'h0;
      shf_n_r <= 5'h0;
      shf_op_r <= 4'h0;
      shf_run_r <= 1'b0;
      shf_done_r <= 1'b0;
    end else begin
      shf_done_r <= shf_run_r && shf_n_r == 5'h0;
      if (st_shf) begin
        shf_v_r <= opnd_a;
        shf_n_r <= opnd_b[4:0];
        shf_op_r <= iss_op;
        shf_run_r <= 1'b1;
      end else if (shf_run_r && shf_n_r != 5'h0) begin // [RQ11]
        shf_n_r <= shf_n_r - 5'h1;
        unique case (shf_op_r)
          mda_pkg::OP_SLL: shf_v_r <= {shf_v_r[30:0], 1'b0};
          mda_pkg::OP_SRL: shf_v_r <= {1'b0, shf_v_r[31:1]};
          mda_pkg::OP_SRA: shf_v_r <= {shf_v_r[31], shf_v_r[31:1]};
          default: shf_v_r <= {shf_v_r[30:0], shf_v_r[31]};
        endcase
      end else begin
        shf_run_r <= 1'b0;
      end
    end
  end

  wire logic done_any = mul_done || div_done || shf_done_r;
  wire logic [31:0] lres = mul_done ? mul_p : div_done ? div_q : shf_v_r;
  wire logic [31:0] sres = iss_op == mda_pkg::OP_ADDI ? opnd_a + opnd_b :
                           iss_op == mda_pkg::OP_OR ? opnd_a | opnd_b : mshift(iss_op, opnd_a, opnd_b[4:0]);

  // ****************************************
  // Issue, scoreboard and write-back
  // ****************************************
  logic wbv_r, lwbv_r;
  logic [4:0] wbd_r, lwbd_r;
  logic [31:0] wbx_r, lwbx_r;

  // Stalled requests leave every register untouched until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_r <= 1'b0;
      exc_r <= 1'b0;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      pdst_r <= 5'h0;
      wbv_r <= 1'b0;
      wbd_r <= 5'h0;
      wbx_r <= 32'h0;
      lwbv_r <= 1'b0;
      lwbd_r <= 5'h0;
      lwbx_r <= 32'h0;
    end else begin
      ack_r <= take;
      exc_r <= take && unsup; // [RQ2]
      wbv_r <= take && is_short; // [RQ10] [RQ13]
      if (take && is_short) begin
        wbd_r <= iss_dst;
        wbx_r <= sres;
      end
      // Second latency cycle: result lands one cycle after the engine finishes
      lwbv_r <= done_any; // [RQ7]
      if (done_any) begin
        lwbd_r <= pdst_r;
        lwbx_r <= lres;
      end
      busy_r <= (take && is_long) || (busy_r && !done_any); // [RQ16]
      // A new long op taken as the old one lands keeps the entry set
      pend_r <= (take && is_long) || (pend_r && !done_any); // [RQ15]
      if (take && is_long) pdst_r <= iss_dst;
    end
  end

  // ****************************************
  // Register port and interrupt
  // ****************************************
  logic awg_r, wg_r, bv_r, arr_r, rv_r, irq_r, awr_r, wr_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r, rd_r;
  logic [3:0] ws_r;
  logic [1:0] br_r, rr_r, stat_r, mask_r;
  wire logic aw_hs = awvalid && awr_r;
  wire logic w_hs = wvalid && wr_r;
  wire logic ar_hs = arvalid && arr_r;
  wire logic do_wr = awg_r && wg_r && !bv_r;
  wire logic wr_ok = awa_r == mda_pkg::ADDR_CTRL || awa_r == mda_pkg::ADDR_MASK ||
                     awa_r == mda_pkg::ADDR_ID || awa_r == mda_pkg::ADDR_CFG ||
                     awa_r == mda_pkg::ADDR_STAT || awa_r == mda_pkg::ADDR_STATE;
  wire logic rd_stat = ar_hs && araddr == mda_pkg::ADDR_STAT;
  wire logic [1:0] events = {done_any, take && unsup};
  wire logic [1:0] stat_nxt = (rd_stat ? 2'h0 : stat_r) | events; // Set beats clear
  wire logic [31:0] cfg = {28'h0, DIV_EN, HAS_MUL, 2'(MUL_MODE)};
  wire logic [31:0] st_word = {29'h0, en_r, pend_r, busy_r};
  wire logic rd_ok = araddr <= mda_pkg::ADDR_STATE && araddr[1:0] == 2'h0;
  wire logic [31:0] rd_mux = araddr == mda_pkg::ADDR_ID ? CORE_ID : // [RQ1]
                             araddr == mda_pkg::ADDR_CFG ? cfg :
                             araddr == mda_pkg::ADDR_CTRL ? {31'h0, en_r} :
                             araddr == mda_pkg::ADDR_STAT ? {30'h0, stat_r} :
                             araddr == mda_pkg::ADDR_MASK ? {30'h0, mask_r} :
                             araddr == mda_pkg::ADDR_STATE ? st_word : 32'h0;

  // Address and data are taken independently; response follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awg_r <= 1'b0;
      wg_r <= 1'b0;
      awr_r <= 1'b0;
      wr_r <= 1'b0;
      bv_r <= 1'b0;
      br_r <= mda_pkg::RESP_OKAY;
      awa_r <= 8'h0;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      en_r <= mda_pkg::CTRL_RST;
      mask_r <= mda_pkg::MASK_RST;
    end else begin
      awr_r <= !awg_r && !aw_hs && !bv_r;
      wr_r <= !wg_r && !w_hs && !bv_r;
      if (aw_hs) begin
        awg_r <= 1'b1;
        awa_r <= awaddr;
      end
      if (w_hs) begin
        wg_r <= 1'b1;
        wd_r <= wdata;
        ws_r <= wstrb;
      end
      if (do_wr) begin
        bv_r <= 1'b1;
        br_r <= wr_ok ? mda_pkg::RESP_OKAY : mda_pkg::RESP_SLVERR;
        if (ws_r[0] && awa_r == mda_pkg::ADDR_CTRL) en_r <= wd_r[mda_pkg::CTRL_EN_BIT];
        if (ws_r[0] && awa_r == mda_pkg::ADDR_MASK) mask_r <= wd_r[1:0];
      end else if (bv_r && bready) begin
        bv_r <= 1'b0;
        awg_r <= 1'b0;
        wg_r <= 1'b0;
      end
    end
  end

  // Single outstanding read; a status read clears what it returned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arr_r <= 1'b0;
      rv_r <= 1'b0;
      rd_r <= 32'h0;
      rr_r <= mda_pkg::RESP_OKAY;
      stat_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      arr_r <= !rv_r && !ar_hs;
      if (ar_hs) begin
        rv_r <= 1'b1;
        rd_r <= rd_mux;
        rr_r <= rd_ok ? mda_pkg::RESP_OKAY : mda_pkg::RESP_SLVERR;
      end else if (rv_r && rready) begin
        rv_r <= 1'b0;
      end
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  assign {iss_ack, iss_exc, wb_valid, wb_dst, wb_data} = {ack_r, exc_r, wbv_r, wbd_r, wbx_r};
  assign {lwb_valid, lwb_dst, lwb_data} = {lwbv_r, lwbd_r, lwbx_r};
  assign {awready, wready, bvalid, bresp} = {awr_r, wr_r, bv_r, br_r};
  assign {arready, rvalid, rdata, rresp, irq} = {arr_r, rv_r, rd_r, rr_r, irq_r};

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  id_read_a: assert property (ar_hs && araddr == mda_pkg::ADDR_ID |=> rdata == CORE_ID) // [RQ1]
    else $error("identity read wrong");
  no_hw_exc_a: assert property (take && (op_mlo || op_div) && !HAS_MUL && !DIV_EN |=> iss_exc && !lwb_valid) // [RQ2]
    else $error("missing exception");
  le_issue_a: assert property (st_mul && MUL_MODE == mda_pkg::MUL_LE |-> ##C_LE mul_done ##1 lwb_valid) // [RQ3]
    else $error("logic multiplier timing");
  full_mul_a: assert property (st_mul && MUL_MODE == mda_pkg::MUL_EMB32 |-> ##2 lwb_valid) // [RQ4]
    else $error("full multiplier latency");
  half_issue_a: assert property (st_mul && MUL_MODE == mda_pkg::MUL_EMB16 |-> !mul_done[*5] ##1 mul_done) // [RQ5]
    else $error("half multiplier timing");
  div_span_a: assert property (st_div |-> ##[4:66] div_done) // [RQ6]
    else $error("divide outside window");
  dep_stall_a: assert property (req && hazard |=> !iss_ack) // [RQ7]
    else $error("dependent op not stalled");
  indep_go_a: assert property (req && is_short && !hazard && en_r |=> iss_ack && wb_valid) // [RQ8]
    else $error("independent op stalled");
  busy_hold_a: assert property (req && is_long && busy_r |=> !iss_ack) // [RQ16]
    else $error("busy slot accepted op");
  e16_gap_a: assert property (st_mul && MUL_MODE == mda_pkg::MUL_EMB16 |=> !st_mul[*5]) // [RQ9]
    else $error("half multiplier reissued early");

  full_mul_c: cover property (st_mul && MUL_MODE == mda_pkg::MUL_EMB32 ##2 lwb_valid);
  div_c: cover property (st_div ##[4:66] div_done);
  stall_c: cover property (req && hazard ##1 req && hazard);
  irq_c: cover property (irq);
endmodule : mda_alu_unit

// ---- rtl/mda_div.sv ----
/*
  Restoring divider, one quotient bit per cycle, skipping the leading zero
  bits of the dividend. Takes 4 to 34 cycles from start to done.
  Assumes start arrives only while idle.
*/
`timescale 1ns/1ps
module mda_div (
  input wire logic aclk,      // Core clock
  input wire logic aresetn,   // Sync reset, low
  input wire logic start,     // Begin a quotient
  input wire logic sgn,       // Signed operands
  input wire logic [31:0] a,  // Dividend
  input wire logic [31:0] b,  // Divisor
  output logic done,          // Quotient ready pulse
  output logic [31:0] q       // Quotient
);
  logic [32:0] rem_r;
  logic [31:0] quo_r;
  logic [31:0] den_r;
  logic [5:0] left_r;
  logic neg_r;
  logic run_r;
  logic fix_r;
  logic done_r;

  // Significant bits, at least two so the shortest run is four cycles
  function automatic logic [5:0] sig_bits(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h2;
    for (int i = 2; i < 32; i++) begin
      if (v[i]) n = 6'(i + 1);
    end
    return n;
  endfunction : sig_bits

  wire logic [31:0] ua = (sgn && a[31]) ? -a : a;
  wire logic [31:0] ub = (sgn && b[31]) ? -b : b;
  wire logic [5:0] nb = sig_bits(ua);
  wire logic [32:0] trial = {rem_r[31:0], quo_r[31]} - {1'b0, den_r};

  // Load, step left_r bits, then fix the sign
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_r <= 33'h0;
      quo_r <= 32'h0;
      den_r <= 32'h0;
      left_r <= 6'h0;
      neg_r <= 1'b0;
      run_r <= 1'b0;
      fix_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= fix_r;
      fix_r <= run_r && left_r == 6'h1;
      if (start) begin
        rem_r <= 33'h0;
        quo_r <= ua << (6'd32 - nb);
        den_r <= ub;
        left_r <= nb;
        neg_r <= sgn && (a[31] ^ b[31]) && b != 32'h0;
        run_r <= 1'b1;
      end else if (run_r) begin
        left_r <= left_r - 6'h1;
        run_r <= left_r != 6'h1;
        // Divide by zero leaves ones in the low nb bits, no trap
        if (!trial[32]) begin
          rem_r <= trial;
          quo_r <= {quo_r[30:0], 1'b1};
        end else begin
          rem_r <= {rem_r[31:0], quo_r[31]};
          quo_r <= {quo_r[30:0], 1'b0};
        end
      end else if (fix_r && neg_r) begin
        quo_r <= -quo_r;
      end
    end
  end

  assign done = done_r;
  assign q = quo_r;
endmodule : mda_div

// ---- rtl/mda_mul.sv ----
/*
  Multiplier core: a CHUNK-bit slice of the multiplier per cycle, or one full
  32x32 product when CHUNK is 32. Holds for ISSUE cycles, then pulses done.
  Assumes start arrives only while idle.
*/
`timescale 1ns/1ps
module mda_mul #(
  parameter int CHUNK = 4,
  parameter int ISSUE = 11
) (
  input wire logic aclk,          // Core clock
  input wire logic aresetn,       // Sync reset, low
  input wire logic start,         // Begin a product
  input wire logic [31:0] a,      // Multiplicand
  input wire logic [31:0] b,      // Multiplier
  input wire logic [1:0] hi_sel,  // 0 low, 1 ss, 2 su, 3 uu
  output logic done,              // Product ready pulse
  output logic [31:0] p           // Product word
);
  localparam int NCH = 32 / CHUNK;

  // Every chunk must fit in the issue window
  if ((32 % CHUNK) != 0 || ISSUE < 1 || (CHUNK != 32 && ISSUE - 1 < NCH)) begin : g_bad
    $error("mda_mul: CHUNK and ISSUE cannot be served");
  end

  logic [31:0] acc_r;
  logic [5:0] idx_r;
  logic [6:0] cnt_r;
  logic done_r;
  wire logic sa = (hi_sel == 2'h1) || (hi_sel == 2'h2);
  wire logic sb = (hi_sel == 2'h1);
  wire logic signed [65:0] full = $signed({sa & a[31], a}) * $signed({sb & b[31], b});
  wire logic [31:0] word = (hi_sel == 2'h0) ? full[31:0] : full[63:32];
  wire logic [31:0] slice = 32'((b >> (idx_r * CHUNK)) & ((33'h1 << CHUNK) - 33'h1));
  wire logic [31:0] part = 32'((a * slice) << (idx_r * CHUNK));

  // Narrow array accumulates one slice per cycle; the rest of the window idles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= 32'h0;
      idx_r <= 6'h0;
      cnt_r <= 7'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= (start && ISSUE == 1) || (cnt_r == 7'h1);
      if (start) begin
        acc_r <= (CHUNK == 32) ? word : 32'h0;
        idx_r <= 6'h0;
        cnt_r <= 7'(ISSUE - 1);
      end else if (cnt_r != 7'h0) begin
        cnt_r <= cnt_r - 7'h1;
        if (CHUNK != 32 && idx_r < 6'(NCH)) begin
          acc_r <= acc_r + part;
          idx_r <= idx_r + 6'h1;
        end
      end
    end
  end

  assign done = done_r;
  assign p = acc_r;
endmodule : mda_mul

// ---- rtl/mda_pkg.sv ----
/*
  Shared constants for the multiply, divide and shift unit: operation codes,
  multiplier build options, cycle counts and the register map.
  Assumes a single clock domain and a 32-bit AXI4-Lite register port.
*/
package mda_pkg;

  // ****************************************
  // Operations presented by the pipeline
  // ****************************************
  typedef enum logic [3:0] {
    OP_ADDI = 4'h0, OP_OR = 4'h1, OP_MUL = 4'h2, OP_MULI = 4'h3,
    OP_MULXSS = 4'h4, OP_MULXSU = 4'h5, OP_MULXUU = 4'h6, OP_DIV = 4'h7,
    OP_DIVU = 4'h8, OP_SLL = 4'h9, OP_SRL = 4'ha, OP_SRA = 4'hb, OP_ROL = 4'hc
  } mda_op_e;

  // ****************************************
  // Multiplier build options
  // ****************************************
  localparam int MUL_NONE = 0;
  localparam int MUL_LE = 1;
  localparam int MUL_EMB32 = 2;
  localparam int MUL_EMB16 = 3;

  // ****************************************
  // Cycle counts and array widths
  // ****************************************
  localparam int LE_ISSUE_CYC = 11;
  localparam int E32_ISSUE_CYC = 1;
  localparam int E16_ISSUE_CYC = 5;
  localparam int LE_CHUNK = 4;
  localparam int E32_CHUNK = 32;
  localparam int E16_CHUNK = 16;
  localparam int RESULT_LAT_CYC = 2;
  localparam int DIV_MIN_CYC = 4;
  localparam int DIV_MAX_CYC = 66;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_ID = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RST = 1'h1;
  localparam int EV_EXC_BIT = 0;
  localparam int EV_DONE_BIT = 1;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mda_pkg

// ---- tb/mda_alu_unit_tb_top.sv ----
/*
  Bench for the multiply, divide and shift unit: pipeline model, AXI4-Lite
  tasks and a queue model of results. Assumes the default 32x32 build with divider.
*/
`timescale 1ns/1ps
module mda_alu_unit_tb_top;
  logic aclk, aresetn, iss_valid, iss_ack, iss_exc, wb_valid, lwb_valid, irq, x;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] iss_op, wstrb, op;
  logic [4:0] iss_dst, iss_src_a, iss_src_b, wb_dst, lwb_dst;
  logic [31:0] opnd_a, opnd_b, wb_data, lwb_data, wdata, rdata, v, a, b;
  logic [7:0] awaddr, araddr;
  logic [1:0] bresp, rresp, r;
  logic [36:0] sq[$], lq[$];
  int err_count = 0, n_checks = 0, w;
  // Identity value is arbitrary
  mda_alu_unit #(.CORE_ID(32'h0000_005a)) u_dut (.*);
  mda_pipe_model u_pipe (.*);
  initial begin aclk = 1'b0; forever #50 aclk = ~aclk; end
  // ****
  // Checking helpers
  // ****
  task automatic chk(input string nm, input logic [36:0] s, e);
    n_checks++;
    if (s !== e) begin err_count++; $display("[FAIL] %s expected %h seen %h", nm, e, s); end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Reference results; op codes follow the package order
  function automatic logic [31:0] ref_fn(logic [3:0] o, logic [31:0] p, q);
    case (o)
      0: return p + q;
      1: return p | q;
      2, 3: return p * q;
      4: return 32'(({{32{p[31]}}, p} * {{32{q[31]}}, q}) >> 32);
      5: return 32'(({{32{p[31]}}, p} * {32'h0, q}) >> 32);
      6: return 32'(({32'h0, p} * {32'h0, q}) >> 32);
      7: return $signed(p) / $signed(q);
      8: return p / q;
      9: return p << q[4:0];
      10: return p >> q[4:0];
      11: return $signed(p) >>> q[4:0];
      default: return (p << q[4:0]) | (p >> (6'd32 - q[4:0]));
    endcase
  endfunction : ref_fn
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    {awvalid, wvalid, awaddr, wdata, bready} <= {2'b11, ad, d, 1'b1};
    for (int k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin bready <= 1'b0; rs = bresp; break; end
    end
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    {arvalid, araddr, rready} <= {1'b1, ad, 1'b1};
    for (int k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin rready <= 1'b0; d = rdata; rs = rresp; break; end
    end
  endtask : rd
  // Every result is compared with its own port's model queue, in issue order within that port
  always @(posedge aclk) if (aresetn) begin
    if (wb_valid === 1'b1) chk("wb", {wb_dst, wb_data}, sq.size() ? sq.pop_front() : 'x);
    if (lwb_valid === 1'b1) chk("lwb", {lwb_dst, lwb_data}, lq.size() ? lq.pop_front() : 'x);
  end
  initial begin repeat (100000) @(posedge aclk); err_count++; print_verdict(); end
  // ****
  // Main sequence
  // ****
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    void'($urandom(32'hb12dccdd));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, v, r);
    chk("id", v, 32'h5a);
    rd(8'h04, v, r);
    chk("cfg", v, 32'he);
    rd(8'h40, v, r);
    chk("unmapped", r, 2'h2);
    // A divide keeps its result pending long enough for the stall to show
    lq.push_back({5'd1, 32'd7});
    u_pipe.issue(7, 1, 2, 3, 63, 9, w, x);
    sq.push_back({5'd4, 32'd105});
    u_pipe.issue(0, 4, 1, 0, 5, 100, w, x);
    chk("dep wait", w, 9);
    lq.push_back({5'd1, 32'd6});
    u_pipe.issue(7, 1, 2, 3, 36, 6, w, x);
    sq.push_back({5'd5, 32'd3});
    u_pipe.issue(1, 5, 5, 6, 1, 2, w, x);
    chk("indep wait", w, 2);
    for (int i = 0; i < 56; i++) begin
      op = 4'(i % 14);
      a = $urandom;
      b = (op == 7 || op == 8) ? ($urandom >> 1) | 1 : $urandom;
      if (op >= 2 && op <= 8) lq.push_back({5'(i), ref_fn(op, a, b)});
      else if (op < 13) sq.push_back({5'(i), ref_fn(op, a, b)});
      u_pipe.issue(op, 5'(i), 5'($urandom), 5'($urandom), a, b, w, x);
      chk("ack exc", {w < 80, x}, {1'b1, op == 13});
    end
    u_pipe.rel();
    for (int k = 0; k < 200 && sq.size() + lq.size() > 0; k++) @(posedge aclk);
    chk("drained", sq.size() + lq.size(), 0);
    rd(8'h0c, v, r);
    wr(8'h10, 32'h3, r);
    chk("wr resp", r, 2'h0);
    chk("irq off", irq, 1'b0);
    u_pipe.issue(13, 9, 9, 9, 0, 0, w, x);
    u_pipe.rel();
    for (int k = 0; k < 5 && irq !== 1'b1; k++) @(posedge aclk);
    chk("irq on", irq, 1'b1);
    rd(8'h0c, v, r);
    chk("status", v, 32'h1);
    for (int k = 0; k < 5 && irq !== 1'b0; k++) @(posedge aclk);
    chk("irq clear", irq, 1'b0);
    print_verdict();
  end
endmodule : mda_alu_unit_tb_top

// ---- tb/mda_pipe_model.sv ----
/*
  Pipeline issue model: presents one request at a time to the unit.
  Assumes the unit acknowledges a held request within 80 cycles.
*/
`timescale 1ns/1ps
module mda_pipe_model (
  input wire logic aclk,       // Core clock
  input wire logic iss_ack,    // Taken pulse
  input wire logic iss_exc,    // Refused op
  output logic iss_valid,      // Request
  output logic [3:0] iss_op,   // Op code
  output logic [4:0] iss_dst,  // Destination
  output logic [4:0] iss_src_a,  // Source a
  output logic [4:0] iss_src_b,  // Source b
  output logic [31:0] opnd_a,  // Operand a
  output logic [31:0] opnd_b   // Operand b
);
  // ****
  // Request driver
  // ****
  initial {iss_valid, iss_op, iss_dst, iss_src_a, iss_src_b, opnd_a, opnd_b} = '0;
  // Held until ack is sampled; a stalled request must not be lost
  task automatic issue(input logic [3:0] op, input logic [4:0] d, sa, sb, input logic [31:0] a, b,
                       output int w, output logic x);
    w = 0;
    {iss_valid, iss_op, iss_dst, iss_src_a, iss_src_b, opnd_a, opnd_b} <= {1'b1, op, d, sa, sb, a, b};
    do begin @(posedge aclk); w++; end while (iss_ack !== 1'b1 && w < 80);
    x = iss_exc;
  endtask : issue
  // Released operands are inverted so stale values are never trusted
  task automatic rel();
    {iss_valid, opnd_a, opnd_b} <= {1'b0, ~opnd_a, ~opnd_b};
  endtask : rel
endmodule : mda_pipe_model
